// ---- inc/sdram_state_regs.svh ----
// timing counts and field layout for the sdram command state logic
`ifndef SDRAM_STATE_REGS_SVH
`define SDRAM_STATE_REGS_SVH

// ------------------------------------------------------------
// clock and counter width
// ------------------------------------------------------------
`define SDR_CLK_PERIOD_NS 50
`define SDR_CNT_W 4
`define SDR_BANKS 4
`define SDR_PIN_W 8

// ------------------------------------------------------------
// times in ns, counts in cycles (least times round up)
// ------------------------------------------------------------
`define SDR_WR_REC_NS 15
`define SDR_WR_REC_CYC ((`SDR_WR_REC_NS + `SDR_CLK_PERIOD_NS - 1) / `SDR_CLK_PERIOD_NS)
`define SDR_ROW_CYCLE_NS 70
`define SDR_ROW_CYCLE_CYC ((`SDR_ROW_CYCLE_NS + `SDR_CLK_PERIOD_NS - 1) / `SDR_CLK_PERIOD_NS)
`define SDR_OPEN_COL_NS 20
`define SDR_OPEN_COL_CYC ((`SDR_OPEN_COL_NS + `SDR_CLK_PERIOD_NS - 1) / `SDR_CLK_PERIOD_NS)
`define SDR_CLOSE_NS 20
`define SDR_CLOSE_CYC ((`SDR_CLOSE_NS + `SDR_CLK_PERIOD_NS - 1) / `SDR_CLK_PERIOD_NS)
`define SDR_SLEEP_EXIT_NS 70
`define SDR_SLEEP_EXIT_CYC ((`SDR_SLEEP_EXIT_NS + `SDR_CLK_PERIOD_NS - 1) / `SDR_CLK_PERIOD_NS)
`define SDR_MODE_ACCESS_CYC 2
`define SDR_BURST_CYC 4

`endif

// ---- inc/sdram_state_pkg.sv ----
// types shared by the sdram command state logic
package sdram_state_pkg;

  typedef enum logic [3:0] {
    CMD_DESELECT,
    CMD_NOP,
    CMD_BURST_STOP,
    CMD_READ,
    CMD_WRITE,
    CMD_ROW_OPEN,
    CMD_ROW_CLOSE,
    CMD_REFRESH,
    CMD_MODE_SET
  } cmd_t;

  typedef enum logic [3:0] {
    BK_IDLE,
    BK_ACTIVATING,
    BK_ACTIVE,
    BK_READ,
    BK_READ_AP,
    BK_WRITE,
    BK_WRITE_AP,
    BK_WR_RECOVER,
    BK_WR_RECOVER_AP,
    BK_PRECHARGING
  } bank_state_t;

  typedef enum logic [2:0] {
    DEV_NORMAL,
    DEV_REFRESHING,
    DEV_MODE_ACCESS,
    DEV_POWER_DOWN,
    DEV_SELF_REFRESH,
    DEV_SR_RECOVERY,
    DEV_SUSPEND
  } dev_mode_t;

endpackage : sdram_state_pkg

// ---- inc/bank_cmd_if.sv ----
// command carrier between the state core and one bank tracker
`timescale 1ns/100ps
interface bank_cmd_if;
  import sdram_state_pkg::*;
  cmd_t cmd;
  logic cmd_en;
  logic hit;
  logic ap;
  logic run;
  logic idle;
  logic illegal;
  bank_state_t state;

  modport core (output cmd, output cmd_en, output hit, output ap, output run,
                input idle, input illegal, input state);
  modport bank (input cmd, input cmd_en, input hit, input ap, input run,
                output idle, output illegal, output state);
endinterface : bank_cmd_if

// ---- core/bank_tracker.sv ----
// per-bank state tracker with recovery and precharge timing
`timescale 1ns/100ps
`include "sdram_state_regs.svh"
module bank_tracker
  import sdram_state_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  bank_cmd_if.bank port
);

  bank_state_t state_r;
  bank_state_t state_nxt;
  logic [`SDR_CNT_W-1:0] cnt_r;
  logic [`SDR_CNT_W-1:0] cnt_nxt;
  logic bst_seen_r;
  logic bst_seen_nxt;
  logic illegal_w;

  wire go = port.cmd_en && port.hit;
  wire burst_stop_cmd = port.cmd_en && port.cmd == CMD_BURST_STOP;
  wire rd = go && port.cmd == CMD_READ;
  wire wr = go && port.cmd == CMD_WRITE;
  wire opn = go && port.cmd == CMD_ROW_OPEN;
  wire cls = go && port.cmd == CMD_ROW_CLOSE;
  wire done = port.run && cnt_r == `SDR_CNT_W'(1);
  wire [`SDR_CNT_W-1:0] cnt_dec = (port.run && cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
  wire [`SDR_CNT_W-1:0] burst_ld = `SDR_CNT_W'(`SDR_BURST_CYC);
  wire [`SDR_CNT_W-1:0] rec_ld = `SDR_CNT_W'(`SDR_WR_REC_CYC);
  wire [`SDR_CNT_W-1:0] pre_ld = `SDR_CNT_W'(`SDR_CLOSE_CYC);

  // ------------------------------------------------------------
  // next state and illegal detection
  // ------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_dec;
    bst_seen_nxt = bst_seen_r;
    illegal_w = 1'b0;
    case (state_r)
      BK_IDLE:
      begin
        illegal_w = rd || wr;
        if (opn)
        begin
          state_nxt = BK_ACTIVATING;
          cnt_nxt = `SDR_CNT_W'(`SDR_OPEN_COL_CYC);
        end
      end
      BK_ACTIVATING:
      begin
        illegal_w = rd || wr || opn || cls;
        if (done)
          state_nxt = BK_ACTIVE;
      end
      BK_ACTIVE, BK_READ, BK_WRITE, BK_WR_RECOVER:
      begin
        illegal_w = opn || ((state_r == BK_WR_RECOVER) && cls);
        if (state_r == BK_WR_RECOVER && done)
          state_nxt = BK_ACTIVE;
        if (state_r == BK_READ && done)
          state_nxt = BK_ACTIVE;
        if (state_r == BK_WRITE && done)
        begin
          state_nxt = BK_WR_RECOVER;
          cnt_nxt = rec_ld;
        end
        if (burst_stop_cmd && (state_r == BK_READ || state_r == BK_WRITE))
          state_nxt = BK_ACTIVE;
        if (rd)
        begin
          state_nxt = port.ap ? BK_READ_AP : BK_READ;
          cnt_nxt = burst_ld;
        end
        else if (wr)
        begin
          state_nxt = port.ap ? BK_WRITE_AP : BK_WRITE;
          cnt_nxt = burst_ld;
        end
        else if (cls && state_r != BK_WR_RECOVER)
        begin
          state_nxt = BK_PRECHARGING;
          cnt_nxt = pre_ld;
        end
      end
      BK_READ_AP, BK_WRITE_AP, BK_WR_RECOVER_AP:
      begin
        illegal_w = rd || wr || opn || cls;
        if (state_r == BK_READ_AP && done)
        begin
          state_nxt = BK_PRECHARGING;
          cnt_nxt = pre_ld;
        end
        if (state_r == BK_WRITE_AP && done)
        begin
          state_nxt = BK_WR_RECOVER_AP;
          cnt_nxt = rec_ld;
          bst_seen_nxt = 1'b0;
        end
        if (state_r == BK_WR_RECOVER_AP)
        begin
          if (burst_stop_cmd)
            bst_seen_nxt = 1'b1;
          if (done)
          begin
            state_nxt = (bst_seen_r || burst_stop_cmd) ? BK_ACTIVE : BK_PRECHARGING;
            cnt_nxt = pre_ld;
          end
        end
      end
      BK_PRECHARGING:
      begin
        illegal_w = rd || wr || opn;
        if (done)
          state_nxt = BK_IDLE;
      end
      default:
        state_nxt = BK_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      state_r <= BK_IDLE;
      cnt_r <= '0;
      bst_seen_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      bst_seen_r <= bst_seen_nxt;
    end
  end

  assign port.state = state_r;
  assign port.idle = state_r == BK_IDLE;
  assign port.illegal = illegal_w;

endmodule : bank_tracker

// ---- core/sdram_cmd_state.sv ----
// command legality and clock-enable state logic of a four-bank sdram
`timescale 1ns/100ps
`include "sdram_state_regs.svh"

// Function
// - write recovery idles back to row active
// - auto-precharge recovery precharges, burst stop keeps row
// - refresh allows only idle commands and burst stop until done
// - mode access returns idle after two clocks
// - bank decoding only with enable high twice
// - idle with enable low enters power-down
// - enable falling with refresh pattern self-refreshes
// - read or write during write recovery starts immediately
// - self-refresh exit needs deselect, no-op or burst stop
// - enable low in active state suspends clock
// - power-down exits to idle on enable rise
// - idle refresh pattern with enable high refreshes
module sdram_cmd_state
  import sdram_state_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [1:0] bank_in,
  input wire logic autoprecharge_addr_bit_in,
  output logic [`SDR_BANKS-1:0] bank_idle_out,
  output logic [`SDR_BANKS-1:0] bank_ap_busy_out,
  output dev_mode_t dev_mode_out,
  output logic illegal_cmd_out,
  output logic suspend_out,
  output logic input_buf_en_out,
  output logic refresh_busy_out
);

  // ------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------
  logic [`SDR_PIN_W-1:0] pin_s1_r;
  logic [`SDR_PIN_W-1:0] pin_s2_r;
  wire [`SDR_PIN_W-1:0] pin_raw = {cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in,
                                   bank_in, autoprecharge_addr_bit_in};

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  wire cke_now = pin_s2_r[7];
  wire cs_n = pin_s2_r[6];
  wire ras_n = pin_s2_r[5];
  wire cas_n = pin_s2_r[4];
  wire we_n = pin_s2_r[3];
  wire [1:0] bank_sel = pin_s2_r[2:1];
  wire ap_bit = pin_s2_r[0];

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  cmd_t cmd_dec;
  assign cmd_dec = cs_n ? CMD_DESELECT :
                   ({ras_n, cas_n, we_n} == 3'h7) ? CMD_NOP :
                   ({ras_n, cas_n, we_n} == 3'h6) ? CMD_BURST_STOP :
                   ({ras_n, cas_n, we_n} == 3'h5) ? CMD_READ :
                   ({ras_n, cas_n, we_n} == 3'h4) ? CMD_WRITE :
                   ({ras_n, cas_n, we_n} == 3'h3) ? CMD_ROW_OPEN :
                   ({ras_n, cas_n, we_n} == 3'h2) ? CMD_ROW_CLOSE :
                   ({ras_n, cas_n, we_n} == 3'h1) ? CMD_REFRESH : CMD_MODE_SET;

  // ------------------------------------------------------------
  // clock-enable edges
  // ------------------------------------------------------------
  logic cke_prev_r;
  wire cke_hold_high = cke_prev_r && cke_now;
  wire cke_fall = cke_prev_r && !cke_now;
  wire cke_rise = !cke_prev_r && cke_now;

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      cke_prev_r <= 1'b0;
    else
      cke_prev_r <= cke_now;
  end

  // ------------------------------------------------------------
  // command classes
  // ------------------------------------------------------------
  wire is_idle_cmd = cmd_dec == CMD_DESELECT || cmd_dec == CMD_NOP;
  wire is_quiet_cmd = is_idle_cmd || cmd_dec == CMD_BURST_STOP;
  wire is_refresh = cmd_dec == CMD_REFRESH;
  wire is_mode_set = cmd_dec == CMD_MODE_SET;
  wire is_bank_cmd = cmd_dec == CMD_READ || cmd_dec == CMD_WRITE ||
                     cmd_dec == CMD_ROW_OPEN || cmd_dec == CMD_ROW_CLOSE ||
                     cmd_dec == CMD_BURST_STOP;
  // exit pattern: deselect, or select with both strobes high
  wire is_exit_pattern = cs_n || (ras_n && cas_n);

  // ------------------------------------------------------------
  // device mode state
  // ------------------------------------------------------------
  dev_mode_t mode_r;
  dev_mode_t mode_nxt;
  logic [`SDR_CNT_W-1:0] cnt_r;
  logic [`SDR_CNT_W-1:0] cnt_nxt;
  logic illegal_dev;
  wire [`SDR_BANKS-1:0] idle_w;
  wire [`SDR_BANKS-1:0] bank_illegal_w;
  wire [`SDR_BANKS-1:0] ap_busy_w;
  wire all_idle = &idle_w;
  wire cnt_done = cnt_r == `SDR_CNT_W'(1);
  wire [`SDR_CNT_W-1:0] cnt_dec = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
  wire bank_cmd_en = mode_r == DEV_NORMAL && cke_hold_high && is_bank_cmd;
  wire bank_run = mode_r != DEV_SUSPEND;

  always_comb
  begin
    mode_nxt = mode_r;
    cnt_nxt = cnt_dec;
    illegal_dev = 1'b0;
    case (mode_r)
      DEV_NORMAL:
      begin
        if (cke_hold_high && (is_refresh || is_mode_set))
        begin
          illegal_dev = !all_idle;
          if (all_idle && is_refresh)
          begin
            mode_nxt = DEV_REFRESHING;
            cnt_nxt = `SDR_CNT_W'(`SDR_ROW_CYCLE_CYC);
          end
          else if (all_idle)
          begin
            mode_nxt = DEV_MODE_ACCESS;
            cnt_nxt = `SDR_CNT_W'(`SDR_MODE_ACCESS_CYC);
          end
        end
        else if (cke_fall && all_idle && is_refresh)
          mode_nxt = DEV_SELF_REFRESH;
        else if (cke_fall && all_idle)
          mode_nxt = DEV_POWER_DOWN;
        else if (cke_fall)
          mode_nxt = DEV_SUSPEND;
      end
      DEV_REFRESHING:
      begin
        illegal_dev = cke_hold_high && !is_quiet_cmd;
        if (cnt_done)
          mode_nxt = DEV_NORMAL;
      end
      DEV_MODE_ACCESS:
      begin
        illegal_dev = cke_hold_high && !is_idle_cmd;
        if (cnt_done)
          mode_nxt = DEV_NORMAL;
      end
      DEV_POWER_DOWN:
      begin
        if (cke_now)
          mode_nxt = DEV_NORMAL;
      end
      DEV_SELF_REFRESH:
      begin
        if (cke_rise && is_exit_pattern)
        begin
          mode_nxt = DEV_SR_RECOVERY;
          cnt_nxt = `SDR_CNT_W'(`SDR_SLEEP_EXIT_CYC);
        end
        else if (cke_rise)
          illegal_dev = 1'b1;
      end
      DEV_SR_RECOVERY:
      begin
        illegal_dev = !is_exit_pattern;
        if (cnt_done)
          mode_nxt = DEV_NORMAL;
      end
      DEV_SUSPEND:
      begin
        if (cke_now)
          mode_nxt = DEV_NORMAL;
      end
      default:
        mode_nxt = DEV_NORMAL;
    endcase
  end

  // ------------------------------------------------------------
  // bank trackers
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `SDR_BANKS; g++)
    begin : gen_bank
      bank_cmd_if bif ();
      assign bif.cmd = cmd_dec;
      assign bif.cmd_en = bank_cmd_en;
      // close with the auto-precharge bit set closes every bank
      assign bif.hit = (bank_sel == 2'(g)) ||
                       (cmd_dec == CMD_ROW_CLOSE && ap_bit);
      assign bif.ap = ap_bit;
      assign bif.run = bank_run;
      assign idle_w[g] = bif.idle;
      assign bank_illegal_w[g] = bif.illegal;
      assign ap_busy_w[g] = bif.state == BK_READ_AP || bif.state == BK_WRITE_AP ||
                            bif.state == BK_WR_RECOVER_AP;
      bank_tracker bank_tracker_inst (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .port(bif.bank)
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // next output values
  // ------------------------------------------------------------
  wire bank_refused = bank_cmd_en && (|bank_illegal_w);
  wire illegal_nxt = illegal_dev || bank_refused;
  // input buffers stay off while powered down or self-refreshing
  wire inbuf_nxt = !(mode_nxt == DEV_POWER_DOWN || mode_nxt == DEV_SELF_REFRESH);
  wire suspend_nxt = mode_nxt == DEV_SUSPEND;
  wire rbusy_nxt = mode_nxt == DEV_REFRESHING || mode_nxt == DEV_SELF_REFRESH;

  // ------------------------------------------------------------
  // mode registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      mode_r <= DEV_NORMAL;
      cnt_r <= '0;
    end
    else
    begin
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // bank status outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      bank_idle_out <= '1;
      bank_ap_busy_out <= '0;
    end
    else
    begin
      bank_idle_out <= idle_w;
      bank_ap_busy_out <= ap_busy_w;
    end
  end

  // ------------------------------------------------------------
  // mode outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      dev_mode_out <= DEV_NORMAL;
      suspend_out <= 1'b0;
      input_buf_en_out <= 1'b1;
      refresh_busy_out <= 1'b0;
    end
    else
    begin
      dev_mode_out <= mode_nxt;
      suspend_out <= suspend_nxt;
      input_buf_en_out <= inbuf_nxt;
      refresh_busy_out <= rbusy_nxt;
    end
  end

  // ------------------------------------------------------------
  // illegal command pulse
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      illegal_cmd_out <= 1'b0;
    else
      illegal_cmd_out <= illegal_nxt;
  end

endmodule : sdram_cmd_state

// ---- verif/sdram_cmd_state_checker.sv ----
// assertions on the ports of the sdram command state logic
`timescale 1ns/100ps
`include "sdram_state_regs.svh"
module sdram_cmd_state_checker
  import sdram_state_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [1:0] bank_in,
  input wire logic autoprecharge_addr_bit_in,
  input wire logic [`SDR_BANKS-1:0] bank_idle_out,
  input wire logic [`SDR_BANKS-1:0] bank_ap_busy_out,
  input dev_mode_t dev_mode_out,
  input wire logic illegal_cmd_out,
  input wire logic suspend_out,
  input wire logic input_buf_en_out,
  input wire logic refresh_busy_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  // ----------------------------------------
  // mode sequences
  // ----------------------------------------
  a_refresh_two_cycles: assert property (dev_mode_out == DEV_REFRESHING &&
    $past(dev_mode_out) != DEV_REFRESHING |->
    ##1 dev_mode_out == DEV_REFRESHING ##1 dev_mode_out == DEV_NORMAL) else $error("refresh len");
  a_mode_two_cycles: assert property (dev_mode_out == DEV_MODE_ACCESS &&
    $past(dev_mode_out) != DEV_MODE_ACCESS |->
    ##1 dev_mode_out == DEV_MODE_ACCESS ##1 dev_mode_out == DEV_NORMAL) else $error("mode len");
  a_sr_recovery_len: assert property (dev_mode_out == DEV_SR_RECOVERY &&
    $past(dev_mode_out) == DEV_SELF_REFRESH |->
    ##1 dev_mode_out == DEV_SR_RECOVERY ##1 dev_mode_out == DEV_NORMAL) else $error("sr exit");
  a_pd_exit_bound: assert property ($rose(cke_in) && dev_mode_out == DEV_POWER_DOWN
    |-> ##[1:4] dev_mode_out == DEV_NORMAL) else $error("pd exit");

  // ----------------------------------------
  // flags against mode
  // ----------------------------------------
  a_refresh_busy_flag: assert property (refresh_busy_out ==
    (dev_mode_out == DEV_REFRESHING || dev_mode_out == DEV_SELF_REFRESH)) else $error("busy");
  a_pd_buffers_off: assert property (dev_mode_out == DEV_POWER_DOWN |->
    !input_buf_en_out && bank_idle_out == 4'hF) else $error("pd bufs");
  a_sr_buffers_off: assert property (dev_mode_out == DEV_SELF_REFRESH |->
    !input_buf_en_out && bank_idle_out == 4'hF) else $error("sr bufs");
  a_suspend_flag: assert property (suspend_out ==
    (dev_mode_out == DEV_SUSPEND)) else $error("suspend flag");
  a_suspend_freeze: assert property (dev_mode_out == DEV_SUSPEND &&
    $past(dev_mode_out) == DEV_SUSPEND && $past(dev_mode_out, 2) == DEV_SUSPEND |->
    $stable(bank_idle_out) &&
    $stable(bank_ap_busy_out)) else $error("freeze");
  a_ap_not_idle: assert property ((bank_ap_busy_out & bank_idle_out) == 4'h0)
    else $error("ap idle");

  c_refresh: cover property (dev_mode_out == DEV_REFRESHING);
  c_self_refresh: cover property (dev_mode_out == DEV_SELF_REFRESH);
  c_suspend: cover property (dev_mode_out == DEV_SUSPEND);
  c_power_down: cover property (dev_mode_out == DEV_POWER_DOWN);
endmodule : sdram_cmd_state_checker

bind sdram_cmd_state sdram_cmd_state_checker sdram_cmd_state_checker_inst (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .cke_in(cke_in), .cs_n_in(cs_n_in),
  .ras_n_in(ras_n_in), .cas_n_in(cas_n_in), .we_n_in(we_n_in), .bank_in(bank_in),
  .autoprecharge_addr_bit_in(autoprecharge_addr_bit_in), .bank_idle_out(bank_idle_out),
  .bank_ap_busy_out(bank_ap_busy_out), .dev_mode_out(dev_mode_out),
  .illegal_cmd_out(illegal_cmd_out), .suspend_out(suspend_out),
  .input_buf_en_out(input_buf_en_out), .refresh_busy_out(refresh_busy_out));

// ---- verif/sdram_ctrl_model.sv ----
// memory controller model driving the command pins
`timescale 1ns/100ps
module sdram_ctrl_model
  import sdram_state_pkg::*;
(
  input wire logic sys_clk_in,
  output logic cke_out,
  output logic cs_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic we_n_out,
  output logic [1:0] bank_out,
  output logic ap_out
);
  initial
  begin
    cke_out = 1'b1;
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hF;
    bank_out = 2'h0;
    ap_out = 1'b0;
  end

  // one command per cycle, launched after the edge
  task automatic send(input cmd_t c, input logic [1:0] b, input logic a, input logic k);
    logic [3:0] p;
    case (c)
      CMD_NOP: p = 4'h7;
      CMD_BURST_STOP: p = 4'h6;
      CMD_READ: p = 4'h5;
      CMD_WRITE: p = 4'h4;
      CMD_ROW_OPEN: p = 4'h3;
      CMD_ROW_CLOSE: p = 4'h2;
      CMD_REFRESH: p = 4'h1;
      CMD_MODE_SET: p = 4'h0;
      default: p = {1'b1, ~ras_n_out, ~cas_n_out, ~we_n_out};
    endcase
    @(posedge sys_clk_in);
    cke_out <= k;
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= p;
    // unselected lines do not keep the old value
    bank_out <= p[3] ? ~bank_out : b;
    ap_out <= p[3] ? ~ap_out : a;
  endtask : send
endmodule : sdram_ctrl_model

// ---- verif/sdram_cmd_state_tb.sv ----
// self-checking bench for the sdram command state logic
`timescale 1ns/100ps
`include "sdram_state_regs.svh"
module sdram_cmd_state_tb
  import sdram_state_pkg::*;
;
  logic sys_clk_in, srst_in, cke, cs_n, ras_n, cas_n, we_n, ap, illegal, suspend, buf_en, rbusy;
  logic [1:0] bank;
  logic [3:0] bank_idle, ap_busy;
  dev_mode_t dev_mode;
  int miscompares, checked, ill_cnt, ap_run, ap_last, c0;

  sdram_ctrl_model sdram_ctrl_model_inst (.sys_clk_in(sys_clk_in), .cke_out(cke),
    .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n),
    .bank_out(bank), .ap_out(ap));
  sdram_cmd_state sdram_cmd_state_inst (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n),
    .bank_in(bank), .autoprecharge_addr_bit_in(ap), .bank_idle_out(bank_idle),
    .bank_ap_busy_out(ap_busy), .dev_mode_out(dev_mode), .illegal_cmd_out(illegal),
    .suspend_out(suspend), .input_buf_en_out(buf_en), .refresh_busy_out(rbusy));

  initial
  begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  // ----------------------------------------
  // monitors and helpers
  // ----------------------------------------
  always @(negedge sys_clk_in)
  begin
    if (illegal === 1'b1) ill_cnt++;
    if (ap_busy[2] === 1'b1) ap_run++;
    else if (ap_run != 0)
    begin
      ap_last = ap_run;
      ap_run = 0;
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic cmd(cmd_t c, logic [1:0] b = 2'h0, logic a = 1'b0, logic k = 1'b1);
    sdram_ctrl_model_inst.send(c, b, a, k);
    #1;
  endtask : cmd

  task automatic idle(int n);
    repeat (n) cmd(CMD_NOP);
  endtask : idle

  task automatic wait_mode(dev_mode_t m);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge sys_clk_in);
      #1;
      if (dev_mode === m) return;
    end
    check("mode wait", 8'(dev_mode), 8'(m));
    print_verdict();
  endtask : wait_mode

  task automatic mode_is(dev_mode_t m);
    @(posedge sys_clk_in);
    #1;
    check("mode", 8'(dev_mode), 8'(m));
  endtask : mode_is

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_refresh;
    c0 = ill_cnt;
    cmd(CMD_REFRESH);
    cmd(CMD_ROW_OPEN);
    cmd(CMD_NOP);
    wait_mode(DEV_REFRESHING);
    check("refresh busy", 8'(rbusy), 8'h01);
    mode_is(DEV_REFRESHING);
    mode_is(DEV_NORMAL);
    idle(4);
    check("open in refresh", 8'(ill_cnt - c0), 8'h01);
    check("idle after refresh", 8'(bank_idle), 8'h0F);
    c0 = ill_cnt;
    cmd(CMD_MODE_SET);
    cmd(CMD_BURST_STOP);
    cmd(CMD_NOP);
    wait_mode(DEV_MODE_ACCESS);
    mode_is(DEV_MODE_ACCESS);
    mode_is(DEV_NORMAL);
    idle(4);
    check("stop in mode set", 8'(ill_cnt - c0), 8'h01);
  endtask : t_refresh

  task automatic t_write;
    c0 = ill_cnt;
    cmd(CMD_ROW_OPEN, 2'h1);
    cmd(CMD_NOP);
    cmd(CMD_WRITE, 2'h1);
    idle(12);
    check("row after write", 8'(bank_idle), 8'h0D);
    cmd(CMD_ROW_OPEN, 2'h2);
    cmd(CMD_NOP);
    cmd(CMD_WRITE, 2'h2, 1'b1);
    cmd(CMD_ROW_OPEN, 2'h0);
    cmd(CMD_ROW_OPEN, 2'h2);
    idle(14);
    check("ap busy length", 8'(ap_last), 8'h05);
    check("ap bank refused", 8'(ill_cnt - c0), 8'h01);
    check("other bank open", 8'(bank_idle), 8'h0C);
    cmd(CMD_ROW_CLOSE, 2'h0, 1'b1);
    idle(6);
    check("all closed", 8'(bank_idle), 8'h0F);
  endtask : t_write

  task automatic t_low_power;
    cmd(CMD_NOP, 2'h0, 1'b0, 1'b0);
    wait_mode(DEV_POWER_DOWN);
    check("pd buffers", 8'(buf_en), 8'h00);
    repeat (4) cmd(CMD_NOP, 2'h0, 1'b0, 1'b0);
    check("pd held", 8'(dev_mode), 8'(DEV_POWER_DOWN));
    cmd(CMD_ROW_OPEN);
    cmd(CMD_NOP);
    wait_mode(DEV_NORMAL);
    idle(4);
    check("open on exit ignored", 8'(bank_idle), 8'h0F);
    c0 = ill_cnt;
    cmd(CMD_REFRESH, 2'h0, 1'b0, 1'b0);
    cmd(CMD_NOP, 2'h0, 1'b0, 1'b0);
    wait_mode(DEV_SELF_REFRESH);
    check("sr busy", 8'({rbusy, buf_en}), 8'h02);
    cmd(CMD_READ);
    repeat (5) cmd(CMD_NOP, 2'h0, 1'b0, 1'b0);
    check("sr bad exit", 8'(ill_cnt - c0), 8'h01);
    check("sr held", 8'(dev_mode), 8'(DEV_SELF_REFRESH));
    cmd(CMD_DESELECT);
    wait_mode(DEV_SR_RECOVERY);
    mode_is(DEV_SR_RECOVERY);
    mode_is(DEV_NORMAL);
  endtask : t_low_power

  task automatic t_suspend;
    cmd(CMD_ROW_OPEN);
    cmd(CMD_NOP);
    cmd(CMD_READ, 2'h0, 1'b1);
    cmd(CMD_NOP, 2'h0, 1'b0, 1'b0);
    wait_mode(DEV_SUSPEND);
    check("suspend on", 8'(suspend), 8'h01);
    repeat (6) cmd(CMD_NOP, 2'h0, 1'b0, 1'b0);
    check("suspend held", 8'(dev_mode), 8'(DEV_SUSPEND));
    check("bank held", 8'({bank_idle, ap_busy}), 8'hE1);
    cmd(CMD_NOP);
    wait_mode(DEV_NORMAL);
    check("suspend off", 8'(suspend), 8'h00);
    idle(8);
    cmd(CMD_ROW_CLOSE, 2'h0);
    idle(4);
    check("closed", 8'(bank_idle), 8'h0F);
  endtask : t_suspend

  initial
  begin
    srst_in = 1'b1;
    repeat (12) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    #1;
    check("reset mode", 8'(dev_mode), 8'(DEV_NORMAL));
    check("reset idle", 8'({bank_idle, ap_busy}), 8'hF0);
    idle(4);
    t_refresh();
    t_write();
    t_low_power();
    t_suspend();
    print_verdict();
  end
endmodule : sdram_cmd_state_tb
